/* File: hdl/clkpwr_pkg.sv */
`default_nettype none
package clkpwr_pkg;
  // timing base
  localparam int unsigned SYS_CLK_HZ = 40_000_000;
  localparam int unsigned RC_HZ = 4_000_000;
  // rc start-up after power-down, least time, rounded up
  localparam int unsigned RC_START_NS = 60_000;
  localparam int unsigned RC_START_CYC =
    (RC_START_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  // flash start-up, counted in rc ticks, rounded up
  localparam int unsigned FLASH_START_NS = 100_000;
  localparam int unsigned FLASH_TICKS =
    (FLASH_START_NS * (RC_HZ / 1_000_000) + 999) / 1000;
  // oscillator cycles before execution resumes
  localparam int unsigned RESUME_TICKS = 4;
  localparam int unsigned MAIN_STABLE_TICKS = 4096;

  // register byte offsets
  localparam logic [7:0] OFS_CLK_SRC = 8'h00;
  localparam logic [7:0] OFS_PLL_CFG = 8'h04;
  localparam logic [7:0] OFS_PLL_CTRL = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MAIN_OSC = 8'h10;
  localparam logic [7:0] OFS_PCONP = 8'h14;
  localparam logic [7:0] OFS_PCLK_DIV = 8'h18;
  localparam logic [7:0] OFS_CLK_DIV = 8'h1c;
  localparam logic [7:0] OFS_PWR_MODE = 8'h20;

  // field positions
  localparam int unsigned SRC_LSB = 0;
  localparam int unsigned WDOG_SEL_BIT = 2;
  localparam int unsigned PLL_N_LSB = 0;
  localparam int unsigned PLL_N_W = 8;
  localparam int unsigned PLL_M_LSB = 8;
  localparam int unsigned PLL_M_W = 15;
  localparam int unsigned PLL_EN_BIT = 0;
  localparam int unsigned PLL_CON_BIT = 1;
  localparam int unsigned CPU_DIV_LSB = 0;
  localparam int unsigned CPU_DIV_W = 8;
  localparam int unsigned USB_DIV_LSB = 8;
  localparam int unsigned USB_DIV_W = 4;
  localparam int unsigned MODE_LSB = 0;

  // reset values
  localparam logic [7:0] PLL_N_RST = 8'h00;
  localparam logic [14:0] PLL_M_RST = 15'h0000;
  localparam logic [7:0] CPU_DIV_RST = 8'h00;
  localparam logic [3:0] USB_DIV_RST = 4'h0;
  localparam logic [31:0] PCONP_RST = 32'hffff_ffff;

  typedef enum logic [1:0] {
    SRC_RC = 2'b00,
    SRC_MAIN = 2'b01,
    SRC_RTC = 2'b10
  } src_e;

  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_IDLE = 2'b01,
    PM_SLEEP = 2'b10,
    PM_PDOWN = 2'b11
  } pmode_e;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_IDLE = 3'b001,
    ST_SLEEP = 3'b010,
    ST_PDOWN = 3'b011,
    ST_RC_START = 3'b100,
    ST_RESUME = 3'b101
  } pstate_e;
endpackage
`default_nettype wire

/* File: hdl/osc_tick_if.sv */
`default_nettype none
// one-cycle ticks, one per rising edge of each oscillator
interface osc_tick_if;
  logic rc;
  logic main;
  logic rtc;
  modport src (output rc, output main, output rtc);
  modport dst (input rc, input main, input rtc);
endinterface
`default_nettype wire

/* File: hdl/osc_sync.sv */
`default_nettype none
module osc_sync (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic internal_rc_osc_i,
  input wire logic main_osc_i,
  input wire logic rtc_osc_i,
  osc_tick_if.src ticks
);
  logic [2:0] meta;
  logic [2:0] stable;
  logic [2:0] last;

  // two flops per pin, then a third for the edge compare;
  // oscillators must stay below half of sys_clk_i
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta <= 3'h0;
      stable <= 3'h0;
      last <= 3'h0;
    end else begin
      meta <= {rtc_osc_i, main_osc_i, internal_rc_osc_i};
      stable <= meta;
      last <= stable;
    end
  end

  assign ticks.rc = stable[0] & ~last[0];
  assign ticks.main = stable[1] & ~last[1];
  assign ticks.rtc = stable[2] & ~last[2];
endmodule
`default_nettype wire

/* File: hdl/periph_clk_gate.sv */
`default_nettype none
module periph_clk_gate #(
  parameter int unsigned DIV_W = 2
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic base_tick_i,
  input wire logic enable_i,
  input wire logic [DIV_W-1:0] div_i,
  output logic pclk_tick_o
);
  logic [DIV_W-1:0] cnt;
  wire last_tick = (cnt >= div_i);

  // divide by div_i+1; a disabled peripheral gets no tick at all
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt <= '0;
      pclk_tick_o <= 1'b0;
    end else if (!enable_i) begin
      cnt <= '0;
      pclk_tick_o <= 1'b0;
    end else begin
      pclk_tick_o <= base_tick_i & last_tick;
      if (base_tick_i) begin
        cnt <= last_tick ? '0 : cnt + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: hdl/clock_power_mode_control.sv */
`default_nettype none
module clock_power_mode_control
  import clkpwr_pkg::*;
#(
  parameter int unsigned NPERIPH = 8,
  parameter int unsigned PDIV_W = 2
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [7:0] paddr_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic internal_rc_osc_i,
  input wire logic main_osc_i,
  input wire logic rtc_osc_i,
  input wire logic pll_lock_i,
  input wire logic irq_i,
  input wire logic wake_irq_i,
  output logic [1:0] pll_input_clock_sel_o,
  output logic pll_input_clock_tick_o,
  output logic cpu_clock_tick_o,
  output logic cpu_run_o,
  output logic pll_enable_o,
  output logic pll_connect_o,
  output logic [7:0] pll_div_n_o,
  output logic [14:0] pll_mul_m_o,
  output logic [7:0] cpu_clock_div_o,
  output logic [3:0] usb_clock_div_o,
  output logic watchdog_unit_tick_o,
  output logic [NPERIPH-1:0] periph_tick_o,
  output logic internal_rc_osc_out_en_o,
  output logic internal_rc_osc_power_o,
  output logic main_osc_en_o,
  output logic flash_power_o,
  output logic flash_ready_o
);
  osc_tick_if ticks ();

  osc_sync u_osc_sync (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .internal_rc_osc_i(internal_rc_osc_i),
    .main_osc_i(main_osc_i),
    .rtc_osc_i(rtc_osc_i),
    .ticks(ticks.src)
  );

  // configuration state
  src_e src_req;
  src_e active_src;
  logic wdog_sel;
  logic [PLL_N_W-1:0] pll_n;
  logic [PLL_M_W-1:0] pll_m;
  logic pll_en;
  logic pll_con;
  logic main_en;
  logic [CPU_DIV_W-1:0] cpu_div;
  logic [USB_DIV_W-1:0] usb_div;
  logic [NPERIPH-1:0] pconp;
  logic [NPERIPH*PDIV_W-1:0] pclk_div;

  // mode and timers
  pstate_e state;
  logic [11:0] wake_cnt;
  logic [8:0] flash_cnt;
  logic flash_ready;
  logic [12:0] main_cnt;
  logic main_stable;
  logic [1:0] lock_sync;
  logic [1:0] wake_sync;

  // apb decode
  wire setup = psel_i & ~penable_i;
  wire access = psel_i & penable_i;
  wire hit_src = (paddr_i == OFS_CLK_SRC);
  wire hit_pcfg = (paddr_i == OFS_PLL_CFG);
  wire hit_pctl = (paddr_i == OFS_PLL_CTRL);
  wire hit_stat = (paddr_i == OFS_STATUS);
  wire hit_main = (paddr_i == OFS_MAIN_OSC);
  wire hit_pconp = (paddr_i == OFS_PCONP);
  wire hit_pdiv = (paddr_i == OFS_PCLK_DIV);
  wire hit_cdiv = (paddr_i == OFS_CLK_DIV);
  wire hit_mode = (paddr_i == OFS_PWR_MODE);
  wire mapped = hit_src | hit_pcfg | hit_pctl | hit_stat | hit_main |
    hit_pconp | hit_pdiv | hit_cdiv | hit_mode;
  wire wr = access & pwrite_i & mapped;

  // state decode
  wire in_run = (state == ST_RUN);
  wire clocks_on = in_run | (state == ST_IDLE);
  wire osc_off = (state == ST_SLEEP) | (state == ST_PDOWN);
  wire lock_s = lock_sync[1];
  wire wake_s = wake_sync[1];
  wire pll_live = pll_en & pll_con & lock_s;
  wire [1:0] req_mode = pwdata_i[MODE_LSB +: 2];
  wire mode_wr = wr & hit_mode & in_run;
  wire enter_sleep = mode_wr & (req_mode == PM_SLEEP);
  wire enter_pd = mode_wr & (req_mode == PM_PDOWN);
  wire src_legal = (pwdata_i[SRC_LSB +: 2] != 2'b11);

  // tick of the currently active pll input
  wire sel_tick = (active_src == SRC_MAIN) ? ticks.main :
    (active_src == SRC_RTC) ? ticks.rtc : ticks.rc;
  wire req_tick = (src_req == SRC_MAIN) ? ticks.main :
    (src_req == SRC_RTC) ? ticks.rtc : ticks.rc;
  // main is not usable until its wake-up timer expired
  wire switch_ok = (src_req != active_src) & req_tick &
    ((src_req != SRC_MAIN) | main_stable);

  // resume condition after sleep or rc start-up
  wire resume_done = (active_src == SRC_MAIN) ? main_stable :
    (wake_cnt == 12'(RESUME_TICKS));
  wire rc_started = (wake_cnt == 12'(RC_START_CYC - 1));

  wire [31:0] status_word = {23'h0, active_src, state, flash_ready,
    main_stable, pll_live, lock_s};
  wire [31:0] rd_mux =
    hit_src ? {29'h0, wdog_sel, src_req} :
    hit_pcfg ? {9'h0, pll_m, pll_n} :
    hit_pctl ? {30'h0, pll_con, pll_en} :
    hit_stat ? status_word :
    hit_main ? {31'h0, main_en} :
    hit_pconp ? 32'(pconp) :
    hit_pdiv ? 32'(pclk_div) :
    hit_cdiv ? {20'h0, usb_div, cpu_div} :
    32'h0;

  // answer in the access phase with no wait state
  assign pready_o = 1'b1;
  assign pslverr_o = access & ~mapped;

  // read data is captured during setup so it is a flop at access
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      prdata_o <= 32'h0;
    end else if (setup) begin
      prdata_o <= pwrite_i ? 32'h0 : rd_mux;
    end
  end

  // level synchronisers for the analog lock and the clockless wake
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lock_sync <= 2'b00;
      wake_sync <= 2'b00;
    end else begin
      lock_sync <= {lock_sync[0], pll_lock_i};
      wake_sync <= {wake_sync[0], wake_irq_i};
    end
  end

  // software settings; sleep and power-down entry clear the pll enable,
  // connect and the cpu and usb dividers (pll n and m and the peripheral dividers are kept),
  // so a later write would not silently resurrect a stale setup
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      src_req <= SRC_RC;
      active_src <= SRC_RC;
      wdog_sel <= 1'b0;
      pll_n <= PLL_N_RST;
      pll_m <= PLL_M_RST;
      pll_en <= 1'b0;
      pll_con <= 1'b0;
      main_en <= 1'b0;
      cpu_div <= CPU_DIV_RST;
      usb_div <= USB_DIV_RST;
      pconp <= PCONP_RST[NPERIPH-1:0];
      pclk_div <= '0;
    end else if (enter_sleep | enter_pd) begin
      pll_en <= 1'b0;
      pll_con <= 1'b0;
      cpu_div <= '0;
      usb_div <= '0;
      if (enter_pd) begin
        main_en <= 1'b0;
        src_req <= SRC_RC;
        active_src <= SRC_RC;
      end
    end else begin
      if (switch_ok) begin
        active_src <= src_req;
      end
      if (wr & hit_src) begin
        if (src_legal) begin
          src_req <= src_e'(pwdata_i[SRC_LSB +: 2]);
        end
        wdog_sel <= pwdata_i[WDOG_SEL_BIT];
      end
      if (wr & hit_pcfg) begin
        pll_n <= pwdata_i[PLL_N_LSB +: PLL_N_W];
        pll_m <= pwdata_i[PLL_M_LSB +: PLL_M_W];
      end
      if (wr & hit_pctl) begin
        pll_en <= pwdata_i[PLL_EN_BIT];
        pll_con <= pwdata_i[PLL_CON_BIT];
      end
      if (wr & hit_main) begin
        main_en <= pwdata_i[0];
      end
      if (wr & hit_pconp) begin
        pconp <= pwdata_i[NPERIPH-1:0];
      end
      if (wr & hit_pdiv) begin
        pclk_div <= pwdata_i[NPERIPH*PDIV_W-1:0];
      end
      if (wr & hit_cdiv) begin
        cpu_div <= pwdata_i[CPU_DIV_LSB +: CPU_DIV_W];
        usb_div <= pwdata_i[USB_DIV_LSB +: USB_DIV_W];
      end
    end
  end

  // power mode sequencer
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= ST_RUN;
      wake_cnt <= 12'h0;
    end else begin
      unique case (state)
        ST_RUN: begin
          wake_cnt <= 12'h0;
          if (mode_wr && req_mode == PM_IDLE) begin
            state <= ST_IDLE;
          end else if (enter_sleep) begin
            state <= ST_SLEEP;
          end else if (enter_pd) begin
            state <= ST_PDOWN;
          end
        end
        ST_IDLE: begin
          if (irq_i | wake_s) begin
            state <= ST_RUN;
          end
        end
        ST_SLEEP: begin
          if (wake_s) begin
            state <= ST_RESUME;
          end
        end
        ST_PDOWN: begin
          if (wake_s) begin
            state <= ST_RC_START;
          end
        end
        ST_RC_START: begin
          // counted on sys_clk_i since the rc is not yet running
          if (rc_started) begin
            state <= ST_RESUME;
            wake_cnt <= 12'h0;
          end else begin
            wake_cnt <= wake_cnt + 12'h1;
          end
        end
        ST_RESUME: begin
          if (resume_done) begin
            state <= ST_RUN;
          end else if (sel_tick) begin
            wake_cnt <= wake_cnt + 12'h1;
          end
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // main oscillator wake-up timer, restarts whenever main stops
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      main_cnt <= 13'h0;
      main_stable <= 1'b0;
    end else if (!main_osc_en_o) begin
      main_cnt <= 13'h0;
      main_stable <= 1'b0;
    end else if (!main_stable && ticks.main) begin
      main_cnt <= main_cnt + 13'h1;
      main_stable <= (main_cnt == 13'(MAIN_STABLE_TICKS - 1));
    end
  end

  // flash wake-up timer; restarts after reset and power-down
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flash_cnt <= 9'h0;
      flash_ready <= 1'b0;
    end else if (state == ST_PDOWN) begin
      flash_cnt <= 9'h0;
      flash_ready <= 1'b0;
    end else if (!flash_ready && ticks.rc) begin
      flash_cnt <= flash_cnt + 9'h1;
      flash_ready <= (flash_cnt == 9'(FLASH_TICKS - 1));
    end
  end

  // clock outputs are registered one-cycle ticks: a switch only
  // happens between whole ticks, so no pulse is ever shortened
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pll_input_clock_tick_o <= 1'b0;
      cpu_clock_tick_o <= 1'b0;
      watchdog_unit_tick_o <= 1'b0;
    end else begin
      pll_input_clock_tick_o <= sel_tick & clocks_on;
      cpu_clock_tick_o <= sel_tick & in_run & ~pll_live;
      watchdog_unit_tick_o <= wdog_sel ? ticks.rtc :
        (ticks.rc & internal_rc_osc_out_en_o);
    end
  end

  // per-peripheral gate and divider, fed while clocks run
  genvar gi;
  generate
    for (gi = 0; gi < NPERIPH; gi++) begin : g_pclk
      periph_clk_gate #(.DIV_W(PDIV_W)) u_gate (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .base_tick_i(sel_tick & clocks_on),
        .enable_i(pconp[gi]),
        .div_i(pclk_div[gi*PDIV_W +: PDIV_W]),
        .pclk_tick_o(periph_tick_o[gi])
      );
    end
  endgenerate

  // analog controls, all decoded from registers
  assign pll_input_clock_sel_o = active_src;
  assign cpu_run_o = in_run;
  assign pll_enable_o = pll_en;
  assign pll_connect_o = pll_live;
  assign pll_div_n_o = pll_n;
  assign pll_mul_m_o = pll_m;
  assign cpu_clock_div_o = cpu_div;
  assign usb_clock_div_o = usb_div;
  assign internal_rc_osc_out_en_o = ~osc_off &
    (state != ST_RC_START);
  assign internal_rc_osc_power_o = (state != ST_PDOWN);
  assign main_osc_en_o = main_en & ~osc_off;
  assign flash_power_o = (state != ST_PDOWN);
  assign flash_ready_o = flash_ready;
endmodule
`default_nettype wire

/* File: testbench/clkpwr_monitor.sv */
`default_nettype none
module clkpwr_monitor
  import clkpwr_pkg::*;
#(
  parameter int unsigned NPERIPH = 8
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] pll_input_clock_sel_o,
  input wire logic pll_input_clock_tick_o,
  input wire logic cpu_clock_tick_o,
  input wire logic cpu_run_o,
  input wire logic pll_enable_o,
  input wire logic pll_connect_o,
  input wire logic [7:0] cpu_clock_div_o,
  input wire logic [3:0] usb_clock_div_o,
  input wire logic [NPERIPH-1:0] periph_tick_o,
  input wire logic internal_rc_osc_out_en_o,
  input wire logic internal_rc_osc_power_o,
  input wire logic main_osc_en_o,
  input wire logic flash_power_o,
  input wire logic flash_ready_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  // cycles since rc power came back; starts saturated so that an
  // idle or sleep wake is never taken for an rc restart
  logic [11:0] since_power;
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      since_power <= 12'hfff;
    end else if (!internal_rc_osc_power_o) begin
      since_power <= 12'h000;
    end else if (since_power != 12'hfff) begin
      since_power <= since_power + 12'h001;
    end
  end

  // tick flops reflect the state of the cycle before, hence the $past
  pll_link_a: assert property (
    pll_connect_o |-> pll_enable_o)
    else $error("pll connected while disabled");
  cpu_tick_a: assert property (
    cpu_clock_tick_o |-> $past(cpu_run_o) && !$past(pll_connect_o))
    else $error("cpu tick while halted or pll live");
  tick_pair_a: assert property (
    cpu_clock_tick_o |-> pll_input_clock_tick_o)
    else $error("cpu tick without pll input tick");
  sleep_clear_a: assert property (
    !internal_rc_osc_out_en_o |-> !pll_enable_o && !pll_connect_o &&
      cpu_clock_div_o == 8'h00 && usb_clock_div_o == 4'h0)
    else $error("pll or dividers kept in sleep");
  // one cycle of grace for ticks launched just before entry
  clock_stop_a: assert property (
    !internal_rc_osc_out_en_o [*2] |-> periph_tick_o == '0 &&
      !pll_input_clock_tick_o && !cpu_clock_tick_o)
    else $error("clock tick while stopped");
  pdown_off_a: assert property (
    !flash_power_o |-> !internal_rc_osc_power_o && !main_osc_en_o &&
      !cpu_run_o && !internal_rc_osc_out_en_o)
    else $error("power-down left something on");
  flash_block_a: assert property (
    !flash_power_o [*2] |-> !flash_ready_o)
    else $error("flash ready while unpowered");
  rc_start_a: assert property (
    $rose(internal_rc_osc_power_o) |-> !cpu_run_o [*8])
    else $error("execution before rc start-up");
  wake_src_a: assert property (
    $rose(internal_rc_osc_power_o) |-> pll_input_clock_sel_o == SRC_RC &&
      !main_osc_en_o && !pll_enable_o)
    else $error("wake not on rc alone");
  rc_wait_a: assert property (
    $rose(cpu_run_o) |-> since_power >= 12'(RC_START_CYC))
    else $error("execution before rc start-up time");
endmodule

bind clock_power_mode_control clkpwr_monitor #(.NPERIPH(NPERIPH)) mon (
  .sys_clk_i, .sys_rst_i, .pll_input_clock_sel_o, .pll_input_clock_tick_o,
  .cpu_clock_tick_o, .cpu_run_o, .pll_enable_o, .pll_connect_o,
  .cpu_clock_div_o, .usb_clock_div_o, .periph_tick_o,
  .internal_rc_osc_out_en_o, .internal_rc_osc_power_o, .main_osc_en_o,
  .flash_power_o, .flash_ready_o
);
`default_nettype wire

/* File: testbench/clock_power_mode_control_tb_top.sv */
`default_nettype none
module clock_power_mode_control_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import clkpwr_pkg::*;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] paddr_i = 8'h00;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [31:0] pwdata_i = 32'h0;
  logic pll_lock_i = 1'b0;
  logic irq_i = 1'b0;
  logic wake_irq_i = 1'b0;
  logic [3:0] osc_cnt = 4'h0;
  logic [31:0] prdata_o, rd;
  logic pready_o, pslverr_o, pll_input_clock_tick_o, cpu_clock_tick_o, er;
  logic [1:0] pll_input_clock_sel_o;
  logic cpu_run_o, pll_enable_o, pll_connect_o, watchdog_unit_tick_o;
  logic [7:0] pll_div_n_o, cpu_clock_div_o, periph_tick_o;
  logic [14:0] pll_mul_m_o;
  logic [3:0] usb_clock_div_o;
  logic internal_rc_osc_out_en_o, internal_rc_osc_power_o, main_osc_en_o;
  logic flash_power_o, flash_ready_o;
  // raw oscillators: rc period 8, main period 4, rtc period 16 cycles
  wire internal_rc_osc_i = osc_cnt[2];
  wire main_osc_i = osc_cnt[1];
  wire rtc_osc_i = osc_cnt[3];
  int mismatches = 0;
  int check_count = 0;
  int n, c0, c1, cw, cc;

  always #12.5 sys_clk_i = ~sys_clk_i;
  // free running, the rtc must keep going through sleep
  always @(posedge sys_clk_i) osc_cnt <= osc_cnt + 4'h1;

  clock_power_mode_control #(.NPERIPH(8), .PDIV_W(2)) dut (
    .sys_clk_i, .sys_rst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .internal_rc_osc_i,
    .main_osc_i, .rtc_osc_i, .pll_lock_i, .irq_i, .wake_irq_i,
    .pll_input_clock_sel_o, .pll_input_clock_tick_o, .cpu_clock_tick_o,
    .cpu_run_o, .pll_enable_o, .pll_connect_o, .pll_div_n_o, .pll_mul_m_o,
    .cpu_clock_div_o, .usb_clock_div_o, .watchdog_unit_tick_o,
    .periph_tick_o, .internal_rc_osc_out_en_o, .internal_rc_osc_power_o,
    .main_osc_en_o, .flash_power_o, .flash_ready_o);

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // one apb transfer; read data and error taken at the pready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    paddr_i <= a;
    pwrite_i <= w;
    pwdata_i <= d;
    @(posedge sys_clk_i);
    penable_i <= 1'b1;
    @(posedge sys_clk_i);
    while (pready_o !== 1'b1) @(posedge sys_clk_i);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  // checks follow cyc, so they sample settled outputs
  task cyc(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask

  task tick_count(input int k);
    c0 = 0;
    c1 = 0;
    cw = 0;
    cc = 0;
    repeat (k) begin
      cyc(1);
      if (periph_tick_o[0] === 1'b1) c0++;
      if (periph_tick_o[1] === 1'b1) c1++;
      if (watchdog_unit_tick_o === 1'b1) cw++;
      if (cpu_clock_tick_o === 1'b1) cc++;
    end
  endtask

  // bounded wait for execution; counts watchdog ticks on the way
  task wait_run(input int lim);
    n = 0;
    cw = 0;
    while (cpu_run_o !== 1'b1 && n < lim) begin
      cyc(1);
      n++;
      if (watchdog_unit_tick_o === 1'b1) cw++;
    end
  endtask

  task t_reset;
    chk(pll_input_clock_sel_o, SRC_RC);
    chk({cpu_run_o, pll_enable_o, main_osc_en_o, flash_power_o},
      4'h9);
    apb(1'b0, OFS_PCONP, 32'h0);
    chk(rd, 32'h0000_00ff);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[8:4], 5'h00);
    apb(1'b0, 8'h24, 32'h0);
    chk(er, 1'b1);
    chk(rd, 32'h0);
    $display("reset test finished");
  endtask

  task t_src;
    apb(1'b1, OFS_CLK_SRC, 32'h6);
    cyc(40);
    chk(pll_input_clock_sel_o, SRC_RTC);
    tick_count(160);
    chk(32'(cw >= 9 && cw <= 11), 32'h1);
    chk(32'(cc >= 9 && cc <= 11), 32'h1);
    apb(1'b1, OFS_CLK_SRC, 32'h0);
    cyc(40);
    chk(pll_input_clock_sel_o, SRC_RC);
    tick_count(160);
    chk(32'(cw >= 19 && cw <= 21), 32'h1);
    chk(32'(cc >= 19 && cc <= 21), 32'h1);
    $display("source test finished");
  endtask

  task t_periph;
    apb(1'b1, OFS_PCONP, 32'hfe);
    apb(1'b1, OFS_PCLK_DIV, 32'hc);
    tick_count(160);
    chk(c0, 32'h0);
    chk(32'(c1 >= 4 && c1 <= 6), 32'h1);
    apb(1'b1, OFS_PCONP, 32'hff);
    apb(1'b1, OFS_PCLK_DIV, 32'h0);
    $display("peripheral test finished");
  endtask

  task t_pll;
    apb(1'b1, OFS_PLL_CFG, 32'h007f_ffff); // 512 MHz from the rc
    cyc(1);
    chk(pll_div_n_o, 8'hff);
    chk(pll_mul_m_o, 15'h7fff);
    apb(1'b1, OFS_PLL_CTRL, 32'h3);
    cyc(6);
    chk(pll_connect_o, 1'b0);
    tick_count(40);
    chk(32'(cc > 0), 32'h1);
    @(posedge sys_clk_i);
    pll_lock_i <= 1'b1;
    cyc(6);
    chk(pll_connect_o, 1'b1);
    tick_count(40);
    chk(cc, 32'h0);
    apb(1'b1, OFS_PLL_CTRL, 32'h0);
    @(posedge sys_clk_i);
    pll_lock_i <= 1'b0;
    $display("pll test finished");
  endtask

  task t_idle;
    apb(1'b1, OFS_PWR_MODE, 32'h1);
    cyc(2);
    chk(cpu_run_o, 1'b0);
    tick_count(40);
    chk(32'(c0 > 0), 32'h1);
    @(posedge sys_clk_i);
    irq_i <= 1'b1;
    cyc(2);
    chk(cpu_run_o, 1'b1);
    @(posedge sys_clk_i);
    irq_i <= 1'b0;
    $display("idle test finished");
  endtask

  task t_sleep;
    apb(1'b1, OFS_CLK_DIV, 32'h305);
    apb(1'b1, OFS_PLL_CTRL, 32'h1);
    cyc(1);
    chk({pll_enable_o, usb_clock_div_o, cpu_clock_div_o}, 13'h1305);
    apb(1'b1, OFS_PWR_MODE, 32'h2);
    cyc(2);
    chk({pll_enable_o, usb_clock_div_o, cpu_clock_div_o}, 13'h0);
    chk({cpu_run_o, internal_rc_osc_out_en_o, internal_rc_osc_power_o,
      flash_power_o}, 4'h3);
    @(posedge sys_clk_i);
    irq_i <= 1'b1;
    cyc(20);
    chk(cpu_run_o, 1'b0);
    @(posedge sys_clk_i);
    irq_i <= 1'b0;
    apb(1'b0, OFS_PLL_CFG, 32'h0);
    chk(rd, 32'h007f_ffff);
    @(posedge sys_clk_i);
    wake_irq_i <= 1'b1;
    wait_run(400);
    chk(32'(cw >= 3 && cw <= 5), 32'h1);
    @(posedge sys_clk_i);
    wake_irq_i <= 1'b0;
    apb(1'b1, OFS_CLK_DIV, 32'h305);
    cyc(1);
    chk({usb_clock_div_o, cpu_clock_div_o}, 12'h305);
    $display("sleep test finished");
  endtask

  task t_pdown;
    apb(1'b1, OFS_MAIN_OSC, 32'h1);
    apb(1'b1, OFS_CLK_SRC, 32'h1);
    cyc(20);
    chk({main_osc_en_o, pll_input_clock_sel_o}, 3'h4);
    n = 0;
    while (pll_input_clock_sel_o !== SRC_MAIN && n < 20000) begin
      cyc(1);
      n++;
    end
    chk(32'(n >= 16000 && n < 17000), 32'h1);
    // sleep on main stops it, so the resume waits its whole timer
    apb(1'b1, OFS_PWR_MODE, 32'h2);
    cyc(2);
    chk(main_osc_en_o, 1'b0);
    @(posedge sys_clk_i);
    wake_irq_i <= 1'b1;
    wait_run(20000);
    chk(32'(n >= 16000 && n < 17000), 32'h1);
    chk(pll_input_clock_sel_o, SRC_MAIN);
    @(posedge sys_clk_i);
    wake_irq_i <= 1'b0;
    apb(1'b1, OFS_PLL_CTRL, 32'h1);
    apb(1'b1, OFS_PWR_MODE, 32'h3);
    cyc(3);
    chk({flash_power_o, internal_rc_osc_power_o, main_osc_en_o,
      pll_enable_o, cpu_run_o, flash_ready_o}, 6'h0);
    @(posedge sys_clk_i);
    wake_irq_i <= 1'b1;
    wait_run(4000);
    chk(32'(n >= RC_START_CYC && n < RC_START_CYC + 200), 32'h1);
    chk(pll_input_clock_sel_o, SRC_RC);
    chk({main_osc_en_o, pll_enable_o, flash_ready_o}, 3'h0);
    @(posedge sys_clk_i);
    wake_irq_i <= 1'b0;
    n = 0;
    while (flash_ready_o !== 1'b1 && n < 5000) begin
      cyc(1);
      n++;
    end
    chk(flash_ready_o, 1'b1);
    $display("power-down test finished");
  endtask

  initial begin
    repeat (12) @(posedge sys_clk_i);
    sys_rst_i <= 1'b0;
    cyc(1);
    t_reset();
    t_src();
    t_periph();
    t_pll();
    t_idle();
    t_sleep();
    t_pdown();
    test_done();
  end

  // the two main-oscillator waits dominate, some 40000 cycles in all
  initial begin
    repeat (60000) @(posedge sys_clk_i);
    mismatches++;
    test_done();
  end
endmodule
`default_nettype wire
